// file: rtl/period_timer.v
/*
 * Eight-bit periodic timer with prescaler, period match and postscaler,
 * reached over an AXI4-Lite slave.
 * Assumes one 250 MHz clock, an asynchronous active-low reset and a master
 * that keeps AXI4-Lite handshake rules.
 */
`timescale 1ns/100ps
`include "period_timer_defs.vh"

// Programming model in brief:
// Each register is one aligned 32-bit word whose low byte holds the value.
// Upper bits of every word read back as zero and are ignored on write.
// Only byte lane 0 of the write strobe matters; other lanes are dropped.
// A write to a mapped word whose lane 0 strobe is low is answered OKAY and changes nothing.
// Unmapped words answer SLVERR; writes there are dropped, reads give zero.
// The counter only moves while the run bit is set.
// Writing the counter or control word restarts both scalers from zero.
// Writing the period value does not touch the scalers or the counter.
// Software should stop the timer before lowering the period below the
// current count; otherwise the counter climbs to FFh and wraps first.
// The match pulse and counter copy lag the internal counter by one cycle.
// Downstream users must allow for that lag when comparing duty values.
// Flags are sticky: hardware sets them, software clears them, and a set
// in the same cycle as a clear is kept, so no event is ever lost.

module period_timer #(
	parameter ADDR_WIDTH = 12
) (
	input wire clk_sys_in,
	input wire rst_n_in,
	input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg match_pulse_out,
	output reg [7:0] timer_count_out,
	output reg periph_irq_out,
	output reg irq_out
);

	// Register state
	reg [7:0] timer_count;
	reg [7:0] period_value;
	reg [6:0] timer_control;
	reg [7:0] peripheral_flags;
	reg [7:0] peripheral_irq_enables;
	reg [7:0] interrupt_control;
	reg [`EVT_WIDTH-1:0] irq_status;
	reg [`EVT_WIDTH-1:0] irq_enable;
	reg [1:0] instr_div;
	reg [3:0] prescale_cnt;
	reg [3:0] postscale_cnt;

	// Bus capture
	reg [ADDR_WIDTH-1:0] wr_addr;
	reg wr_addr_held;
	reg [31:0] wr_data;
	reg [3:0] wr_strb;
	reg wr_data_held;

	wire instr_tick;
	wire [3:0] prescale_last;
	wire count_step;
	wire period_hit;
	wire post_hit;
	wire wr_go;
	wire wr_lane0;
	wire wr_count;
	wire wr_control;
	wire wr_period;
	wire wr_flags;
	wire wr_pie;
	wire wr_intctl;
	wire wr_irq_clear;
	wire wr_irq_enable;
	wire wr_mapped;
	wire [`EVT_WIDTH-1:0] evt;
	wire [7:0] next_flags;
	wire [`EVT_WIDTH-1:0] next_irq_status;
	reg [31:0] rd_value;
	reg rd_ok;

	// Word index decode from a byte address, used by both channels
	function [7:0] word_index;
		input [ADDR_WIDTH-1:0] addr;
		begin
			word_index = addr[9:2];
		end
	endfunction

	// Prescale terminal count from control bits 1:0
	function [3:0] prescale_limit;
		input [1:0] sel;
		begin
			if (sel[1]) begin
				prescale_limit = `PRESCALE_16_LAST;
			end else if (sel[0]) begin
				prescale_limit = `PRESCALE_4_LAST;
			end else begin
				prescale_limit = 4'h0;
			end
		end
	endfunction

	// Quarter-rate instruction clock enable
	assign instr_tick = (instr_div == `INSTR_CLK_DIV);
	assign prescale_last = prescale_limit(timer_control[`CTL_PRESCALE_LSB +: 2]);
	assign count_step = timer_control[`CTL_RUN_BIT] && instr_tick &&
		(prescale_cnt == prescale_last);
	assign period_hit = count_step && (timer_count == period_value);
	assign post_hit = period_hit &&
		(postscale_cnt == timer_control[`CTL_POSTSCALE_LSB +: 4]);

	// Write decode, performed once address and data are both held
	assign wr_go = wr_addr_held && wr_data_held && !s_axi_bvalid;
	assign wr_lane0 = wr_go && wr_strb[0];
	assign wr_count = wr_lane0 && (word_index(wr_addr) == `IDX_TIMER_COUNT);
	assign wr_control = wr_lane0 && (word_index(wr_addr) == `IDX_TIMER_CONTROL);
	assign wr_period = wr_lane0 && (word_index(wr_addr) == `IDX_PERIOD_VALUE);
	assign wr_flags = wr_lane0 && (word_index(wr_addr) == `IDX_PERIPHERAL_FLAGS);
	assign wr_pie = wr_lane0 && (word_index(wr_addr) == `IDX_PERIPHERAL_IRQ_ENABLES);
	assign wr_intctl = wr_lane0 && (word_index(wr_addr) == `IDX_INTERRUPT_CONTROL);
	assign wr_irq_clear = wr_lane0 && (word_index(wr_addr) == `IDX_IRQ_CLEAR);
	assign wr_irq_enable = wr_lane0 && (word_index(wr_addr) == `IDX_IRQ_ENABLE);
	assign wr_mapped = (word_index(wr_addr) == `IDX_TIMER_COUNT) ||
		(word_index(wr_addr) == `IDX_TIMER_CONTROL) ||
		(word_index(wr_addr) == `IDX_PERIOD_VALUE) ||
		(word_index(wr_addr) == `IDX_PERIPHERAL_FLAGS) ||
		(word_index(wr_addr) == `IDX_PERIPHERAL_IRQ_ENABLES) ||
		(word_index(wr_addr) == `IDX_INTERRUPT_CONTROL) ||
		(word_index(wr_addr) == `IDX_IRQ_CLEAR) ||
		(word_index(wr_addr) == `IDX_IRQ_ENABLE) ||
		(word_index(wr_addr) == `IDX_IRQ_STATUS);

	// Flag register: software write, then hardware set wins
	assign next_flags = (wr_flags ? (wr_data[7:0] & `PERIPH_FLAGS_MASK) : peripheral_flags) |
		({7'h00, post_hit} << `FLAG_PERIOD_MATCH_BIT);
	assign evt = {post_hit, period_hit};
	assign next_irq_status = (irq_status & ~(wr_irq_clear ? wr_data[`EVT_WIDTH-1:0] :
		{`EVT_WIDTH{1'b0}})) | evt;

	// The divider makes a one-cycle enable every fourth system clock.
	// It is never cleared by bus writes, so a restart of the scalers may
	// land anywhere within the current quarter period.
	// That costs up to three cycles of phase on the first step after a
	// counter or control write; the trade keeps one divider for all users.
	// Instruction clock divider, free running
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			instr_div <= 2'h0;
		end else begin
			instr_div <= instr_div + 2'h1;
		end
	end

	// The prescaler advances only on quarter ticks while running; the control
	// write that stops the timer also clears its partial prescale count.
	// The postscaler advances once per period match and clears on its own
	// terminal count, which also raises the postscaled event.
	// A counter or control write in the same cycle as a match wins: the scalers clear and
	// the match still counts toward the flag through its own path.
	// Prescaler and postscaler, cleared by count or control writes
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prescale_cnt <= 4'h0;
			postscale_cnt <= 4'h0;
		end else if (wr_count || wr_control) begin
			prescale_cnt <= 4'h0;
			postscale_cnt <= 4'h0;
		end else begin
			if (timer_control[`CTL_RUN_BIT] && instr_tick) begin
				if (prescale_cnt == prescale_last) begin
					prescale_cnt <= 4'h0;
				end else begin
					prescale_cnt <= prescale_cnt + 4'h1;
				end
			end
			if (post_hit) begin
				postscale_cnt <= 4'h0;
			end else if (period_hit) begin
				postscale_cnt <= postscale_cnt + 4'h1;
			end
		end
	end

	// A software counter write takes priority over a wrap or a step in the
	// same cycle, so the written value is what software reads back.
	// The wrap happens on the step at which the counter equals the period,
	// giving a period of the register value plus one steps.
	// A period of zero therefore makes a match on every counter step.
	// Control bit 7 has no storage and always reads back as zero.
	// Counter, period and control registers
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timer_count <= `RST_TIMER_COUNT;
			period_value <= `RST_PERIOD_VALUE;
			timer_control <= 7'h00;
		end else begin
			if (wr_count) begin
				timer_count <= wr_data[7:0];
			end else if (period_hit) begin
				timer_count <= 8'h00;
			end else if (count_step) begin
				timer_count <= timer_count + 8'h01;
			end
			if (wr_period) begin
				period_value <= wr_data[7:0];
			end
			if (wr_control) begin
				timer_control <= wr_data[6:0];
			end
		end
	end

	// Two interrupt paths exist side by side.
	// The peripheral path follows the flag, its enable and the two global
	// enables, and needs software to clear the flag.
	// The sticky status path records raw and postscaled matches; a write of
	// ones to the clear word drops those bits unless an event arrives then.
	// Interrupt flags and enables
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			peripheral_flags <= `RST_FLAGS;
			peripheral_irq_enables <= `RST_FLAGS;
			interrupt_control <= `RST_FLAGS;
			irq_status <= {`EVT_WIDTH{1'b0}};
			irq_enable <= {`EVT_WIDTH{1'b0}};
		end else begin
			peripheral_flags <= next_flags;
			irq_status <= next_irq_status;
			if (wr_pie) begin
				peripheral_irq_enables <= wr_data[7:0] & `PERIPH_FLAGS_MASK;
			end
			if (wr_intctl) begin
				interrupt_control <= wr_data[7:0];
			end
			if (wr_irq_enable) begin
				irq_enable <= wr_data[`EVT_WIDTH-1:0];
			end
		end
	end

	// Registered side outputs for the serial port, PWM unit and interrupt lines
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			match_pulse_out <= 1'b0;
			timer_count_out <= 8'h00;
			periph_irq_out <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			match_pulse_out <= period_hit;
			timer_count_out <= timer_count;
			periph_irq_out <= interrupt_control[`INTCTL_GLOBAL_BIT] &&
				interrupt_control[`INTCTL_PERIPH_BIT] &&
				|(next_flags & peripheral_irq_enables);
			irq_out <= |(next_irq_status & irq_enable);
		end
	end

	// Address and data ready are one-cycle pulses, raised the cycle after
	// their valid is seen and never while a word is already held.
	// The register update and the response both happen the cycle after the
	// later of the two is taken; held words are released on the response
	// handshake, so only one write is ever in flight.
	// Write channels: take address and data in either order, answer after both
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			wr_addr <= {ADDR_WIDTH{1'b0}};
			wr_addr_held <= 1'b0;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			wr_data_held <= 1'b0;
		end else begin
			s_axi_awready <= !wr_addr_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !wr_data_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				wr_addr <= s_axi_awaddr;
				wr_addr_held <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
				wr_data_held <= 1'b1;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? 2'h0 : 2'h2;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				wr_addr_held <= 1'b0;
				wr_data_held <= 1'b0;
			end
		end
	end

	// Read mux
	always @* begin
		rd_value = 32'h0000_0000;
		rd_ok = 1'b1;
		case (word_index(s_axi_araddr))
			`IDX_TIMER_COUNT: rd_value[7:0] = timer_count;
			`IDX_TIMER_CONTROL: rd_value[7:0] = {1'b0, timer_control};
			`IDX_PERIOD_VALUE: rd_value[7:0] = period_value;
			`IDX_PERIPHERAL_FLAGS: rd_value[7:0] = peripheral_flags;
			`IDX_PERIPHERAL_IRQ_ENABLES: rd_value[7:0] = peripheral_irq_enables;
			`IDX_INTERRUPT_CONTROL: rd_value[7:0] = interrupt_control;
			`IDX_IRQ_STATUS: rd_value[`EVT_WIDTH-1:0] = irq_status;
			`IDX_IRQ_ENABLE: rd_value[`EVT_WIDTH-1:0] = irq_enable;
			`IDX_IRQ_CLEAR: rd_value = 32'h0000_0000;
			default: rd_ok = 1'b0;
		endcase
	end

	// The read address is decoded while it is offered and the data word is
	// latched at the accepting edge, so the response never changes while
	// it waits for the master to take it.
	// No new read is accepted while a response is still pending.
	// Read channel: one cycle to accept, data the next cycle
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_value;
				s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// file: pkg/period_timer_defs.vh
/*
 * Constants for the 8-bit period timer: register offsets, field positions,
 * reset values and clock ratios.
 * Assumes inclusion by bare name from the timer module only.
 */
`ifndef PERIOD_TIMER_DEFS_VH
`define PERIOD_TIMER_DEFS_VH

// Register indices as printed; byte address is four times the index
`define IDX_INTERRUPT_CONTROL 8'h0b
`define IDX_PERIPHERAL_FLAGS 8'h0c
`define IDX_TIMER_COUNT 8'h11
`define IDX_TIMER_CONTROL 8'h12
`define IDX_PERIPHERAL_IRQ_ENABLES 8'h8c
`define IDX_PERIOD_VALUE 8'h92
`define IDX_IRQ_STATUS 8'hc0
`define IDX_IRQ_CLEAR 8'hc1
`define IDX_IRQ_ENABLE 8'hc2

// Timer control fields
`define CTL_PRESCALE_LSB 0
`define CTL_RUN_BIT 2
`define CTL_POSTSCALE_LSB 3
`define CTL_WRITE_MASK 8'h7f

// Flag and enable bit positions
`define FLAG_PERIOD_MATCH_BIT 1
`define INTCTL_GLOBAL_BIT 7
`define INTCTL_PERIPH_BIT 6
`define PERIPH_FLAGS_MASK 8'hf7

// Reset values
`define RST_TIMER_COUNT 8'h00
`define RST_TIMER_CONTROL 8'h00
`define RST_PERIOD_VALUE 8'hff
`define RST_FLAGS 8'h00

// Instruction clock is the system clock divided by four
`define INSTR_CLK_DIV 2'h3
`define PRESCALE_4_LAST 4'h3
`define PRESCALE_16_LAST 4'hf

// Sticky status events: bit 0 period match, bit 1 postscaled match
`define EVT_WIDTH 2

`endif

// file: sim/period_timer_checker.sv
/* Port-level assertions for the period timer.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/100ps
module period_timer_checker (
	input wire clk_sys_in,
	input wire rst_n_in,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire match_pulse_out,
	input wire [7:0] timer_count_out,
	input wire irq_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	// Bus request steps
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	match_gap_a: assert property (match_pulse_out |=> !match_pulse_out [*3])
		else $error("match pulses closer than four cycles");
	match_zero_a: assert property (match_pulse_out |=> timer_count_out == 8'h00)
		else $error("match pulse without counter at zero");
	reset_idle_a: assert property ($rose(rst_n_in) |-> timer_count_out == 8'h00 && !irq_out)
		else $error("counter or interrupt not clear after reset");
	write_answer_a: assert property (wr_taken |-> ##[1:8] s_axi_bvalid)
		else $error("write response missing");
	read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read data late");
	bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	rresp_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");
	aready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("address ready held");
endmodule
bind period_timer period_timer_checker chk (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_out(irq_out),
	.match_pulse_out(match_pulse_out), .timer_count_out(timer_count_out));

// file: sim/timebase_sink.sv
/* Time-base consumer in the place of the PWM unit and serial port.
   Assumes the match pulse and counter copy of one timer. */
`timescale 1ns/100ps
module timebase_sink (
	input wire clk_sys_in,
	input wire rst_n_in,
	input wire match_pulse_in,
	input wire [7:0] timer_count_in,
	output reg [15:0] pulse_total_out,
	output reg [15:0] gap_out,
	output reg [7:0] peak_out
);
	reg [15:0] since;
	reg [7:0] prev;
	// Counts pulses, cycles between them and the count held before a wrap
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			{pulse_total_out, gap_out, peak_out, since, prev} <= 'b0;
		end else begin
			prev <= timer_count_in;
			since <= match_pulse_in ? 16'h0001 : since + 16'h0001;
			if (match_pulse_in) begin
				pulse_total_out <= pulse_total_out + 16'h0001;
				gap_out <= since;
				peak_out <= prev;
			end
		end
	end
endmodule

// file: sim/tb_period_timer.sv
/* Self-checking bench for the period timer.
   Assumes the bound checker and the time-base sink. */
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_period_timer;
	reg clk_sys_in, rst_n_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	reg s_axi_arvalid, s_axi_rready;
	reg [11:0] s_axi_awaddr, s_axi_araddr;
	reg [31:0] s_axi_wdata;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire match_pulse_out, periph_irq_out, irq_out;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [7:0] timer_count_out, peak;
	wire [15:0] pulses, gap;
	int err_total, samples_checked, cycles;
	logic [31:0] rd_val;
	logic [1:0] rd_resp;
	period_timer DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_out(irq_out),
		.match_pulse_out(match_pulse_out), .timer_count_out(timer_count_out),
		.periph_irq_out(periph_irq_out));
	timebase_sink sink (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.match_pulse_in(match_pulse_out), .timer_count_in(timer_count_out),
		.pulse_total_out(pulses), .gap_out(gap), .peak_out(peak));
	// Clock
	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end
	// Hang guard
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			end_of_test();
		end
	end
	task automatic end_of_test;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input [11:0] a, input [7:0] d);
		@(posedge clk_sys_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge clk_sys_in);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input [11:0] a);
		@(posedge clk_sys_in);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge clk_sys_in);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd_val = s_axi_rdata;
		rd_resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic t_reset;
		logic [11:0] adr [5] = '{12'h044, 12'h048, 12'h248, 12'h030, 12'h230};
		logic [7:0] val [5] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
		for (int i = 0; i < 5; i++) begin
			rd(adr[i]);
			`CHK(rd_val, {24'h00_0000, val[i]})
		end
		rd(12'h100);
		`CHK({rd_resp, rd_val}, 34'h2_0000_0000)
	endtask
	task automatic t_rw;
		wr(12'h048, 8'hff);
		rd(12'h048);
		`CHK(rd_val, 32'h0000_007f)
		wr(12'h048, 8'h00);
		wr(12'h248, 8'h5a);
		rd(12'h248);
		`CHK(rd_val, 32'h0000_005a)
		wr(12'h044, 8'h33);
		wr(12'h048, 8'h78);
		repeat (40) @(posedge clk_sys_in);
		rd(12'h044);
		`CHK(rd_val, 32'h0000_0033)
		`CHK(timer_count_out, 8'h33)
	endtask
	task automatic t_prescale;
		logic [15:0] exp [4] = '{16'h0010, 16'h0040, 16'h0100, 16'h0100};
		logic [15:0] snap;
		wr(12'h248, 8'h03);
		for (int c = 0; c < 4; c++) begin
			wr(12'h048, 8'h00);
			wr(12'h044, 8'h00);
			snap = pulses;
			wr(12'h048, 8'h04 + c[7:0]);
			while (pulses != snap + 16'h0002) @(posedge clk_sys_in);
			`CHK(gap, exp[c])
			`CHK(peak, 8'h03)
		end
	endtask
	task automatic t_postscale;
		logic [7:0] ctl [3] = '{8'h04, 8'h0c, 8'h7c};
		logic [15:0] n [3] = '{16'h0001, 16'h0002, 16'h0010};
		logic [15:0] snap;
		wr(12'h248, 8'h00);
		wr(12'h02c, 8'hc0);
		wr(12'h230, 8'h02);
		wr(12'h308, 8'h02);
		for (int i = 0; i < 3; i++) begin
			wr(12'h048, 8'h00);
			wr(12'h030, 8'h00);
			wr(12'h304, 8'h03);
			`CHK({periph_irq_out, irq_out}, 2'b00)
			snap = pulses;
			wr(12'h048, ctl[i]);
			while (!irq_out) @(posedge clk_sys_in);
			repeat (2) @(posedge clk_sys_in);
			`CHK(pulses - snap, n[i])
		end
		wr(12'h048, 8'h00);
		rd(12'h030);
		`CHK({periph_irq_out, rd_val[1]}, 2'b11)
		wr(12'h308, 8'h00);
		repeat (2) @(posedge clk_sys_in);
		`CHK(irq_out, 1'b0)
		wr(12'h308, 8'h02);
		repeat (2) @(posedge clk_sys_in);
		`CHK(irq_out, 1'b1)
		wr(12'h304, 8'h03);
		repeat (2) @(posedge clk_sys_in);
		`CHK(irq_out, 1'b0)
	endtask
	// Main sequence
	initial begin
		rst_n_in = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		repeat (20) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		t_reset();
		t_rw();
		t_prescale();
		t_postscale();
		end_of_test();
	end
endmodule
